// file: hw/lbb_fifo.sv
`timescale 1ns/10ps
module lbb_fifo #(
  parameter int W = 32,
  parameter int D = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_sn,
  // fill side
  lbb_fifo_if.snk f,
  // drain side
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int PW = $clog2(D);
  localparam int CW = $clog2(D + 1);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;
    logic ov;
    logic [W-1:0] od;
  } lbb_fifo_st_t;

  lbb_fifo_st_t q, d;
  logic push, pop;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    d = q;
    push = f.push_valid && (q.cnt != CW'(D));
    // output stage refills whenever it is empty or being taken
    pop = (q.cnt != '0) && (!q.ov || out_ready);
    if (q.ov && out_ready) begin
      d.ov = 1'b0;
    end
    if (pop) begin
      d.od = q.mem[q.rp];
      d.ov = 1'b1;
      d.rp = q.rp + 1'b1;
    end
    if (push) begin
      d.mem[q.wp] = f.push_data;
      d.wp = q.wp + 1'b1;
    end
    d.cnt = q.cnt + CW'(push) - CW'(pop);
  end

  always_ff @(posedge clk or negedge rst_sn) begin
    if (!rst_sn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign f.push_ready = q.cnt != CW'(D);
  assign f.room = 4'(CW'(D) - q.cnt);
  assign out_valid = q.ov;
  assign out_data = q.od;
endmodule

// file: hw/lbb_fifo_if.sv
`timescale 1ns/10ps
interface lbb_fifo_if;
  logic push_valid;
  logic push_ready;
  logic [31:0] push_data;
  logic [3:0] room;
  modport src (output push_valid, output push_data,
    input push_ready, input room);
  modport snk (input push_valid, input push_data,
    output push_ready, output room);
endinterface

// file: hw/lbb_master.sv
`timescale 1ns/10ps
module lbb_master (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // transfer request
  input wire logic req_valid,
  input wire logic [29:0] req_addr,
  input wire logic [7:0] req_len,
  output logic req_ready,
  // configuration
  input wire logic cfg_wr,
  input wire logic [15:0] cfg_wdata,
  output logic [15:0] cfg_rdata,
  // bus arbitration
  output logic hold_req,
  input wire logic hold_ack,
  input wire logic boff_n,
  input wire logic ahold,
  // bus cycle
  output logic ads_n,
  output logic blast_n,
  output logic cmd_oe_n,
  output logic [29:0] addr_out,
  output logic [29:0] addr_oe_n,
  input wire logic brdy_n,
  input wire logic ready_return_input_n,
  input wire logic [31:0] bus_data,
  // read data out
  output logic out_valid,
  output logic [31:0] out_data,
  input wire logic out_ready
);
  typedef struct packed {
    lbb_pkg::lbb_state_t st;
    logic [29:0] addr;
    logic [7:0] remain;
    logic [1:0] beat;
    logic lin;
    logic first;
    logic hold;
    logic ads_n;
    logic blast_n;
    logic cmd_oe_n;
    logic [29:0] aoe_n;
    logic [1:0] gap;
    logic rdy;
    logic [15:0] cfg;
    logic push_v;
    logic [31:0] push_d;
  } lbb_mst_t;

  localparam lbb_mst_t RST = '{st: lbb_pkg::ST_IDLE, addr: '0,
    remain: '0, beat: '0, lin: 1'b0, first: 1'b0, hold: 1'b0,
    ads_n: 1'b1, blast_n: 1'b1, cmd_oe_n: 1'b1, aoe_n: '1, gap: '0,
    rdy: 1'b0, cfg: lbb_pkg::CFG_RESET, push_v: 1'b0, push_d: '0};

  lbb_mst_t q, d;
  logic [1:0] rst_q;
  logic rst_sn;
  lbb_fifo_if fi ();
  logic boff, brdy, rtn, xfer, start_lin, room_ok, owned, last_q;
  logic [4:0] cache_line_length_field;
  logic [29:0] fmask;

  function automatic logic last_beat(input logic lin,
      input logic [1:0] beat, input logic [7:0] remain);
    last_beat = !lin || (beat == 2'(lbb_pkg::BURST_LEN - 1)) ||
      (remain == 8'h01);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_sn = rst_q[1];

  ////////////////////////////////////////////////////////////////////////
  // synchronous bus sampling
  assign boff = !boff_n;
  assign brdy = !brdy_n;
  assign rtn = !ready_return_input_n;
  assign xfer = brdy || rtn;
  assign cache_line_length_field = q.cfg[lbb_pkg::CLL_MSB:lbb_pkg::CLL_LSB];
  assign room_ok = fi.room >= lbb_pkg::ROOM_MIN;
  assign last_q = last_beat(q.lin, q.beat, q.remain);
  // fresh sequence bursts only from aligned address
  assign start_lin = (q.beat == 2'h0) ?
    ((q.addr[1:0] == 2'h0) && (q.remain >= 8'(lbb_pkg::BURST_LEN))) :
    q.lin;

  // floated range per line length code
  always_comb begin
    case (cache_line_length_field)
      lbb_pkg::CLL_A2: fmask = lbb_pkg::MASK_A2;
      lbb_pkg::CLL_A3: fmask = lbb_pkg::MASK_A3;
      lbb_pkg::CLL_A4: fmask = lbb_pkg::MASK_A4;
      lbb_pkg::CLL_A5: fmask = lbb_pkg::MASK_A5;
      lbb_pkg::CLL_A6: fmask = lbb_pkg::MASK_A6;
      default: fmask = 30'h00000000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    d = q;
    d.push_v = 1'b0;
    d.push_d = bus_data;
    if (cfg_wr) begin
      d.cfg = cfg_wdata;
    end
    case (q.st)
      lbb_pkg::ST_IDLE: begin
        if (req_valid && q.rdy && (req_len != 8'h00)) begin
          d.addr = req_addr;
          d.remain = req_len;
          d.beat = 2'h0;
          d.hold = 1'b1;
          d.st = lbb_pkg::ST_HREQ;
        end
      end
      lbb_pkg::ST_HREQ: begin
        if (hold_ack) begin
          d.st = lbb_pkg::ST_WAIT;
          d.cmd_oe_n = 1'b0;
        end
      end
      lbb_pkg::ST_WAIT: begin
        // commands stay driven, strobe held off
        d.ads_n = 1'b1;
        // no new strobe while address is held
        if (!ahold && room_ok) begin
          d.st = lbb_pkg::ST_T1;
          d.ads_n = 1'b0;
          d.lin = start_lin;
          d.first = (q.beat == 2'h0) ? 1'b0 : q.first;
          d.blast_n = !last_beat(start_lin, q.beat, q.remain);
        end
      end
      lbb_pkg::ST_T1: begin
        d.ads_n = 1'b1;
        // hold in first state suspends the burst
        if (ahold) begin
          d.st = lbb_pkg::ST_WAIT;
          d.blast_n = 1'b1;
        end else begin
          d.st = lbb_pkg::ST_T2;
        end
      end
      lbb_pkg::ST_T2: begin
        // no ready: address and strobe left as they are
        if (xfer) begin
          d.push_v = 1'b1;
          d.addr = q.addr + 30'h1;
          d.remain = q.remain - 8'h01;
          d.first = 1'b1;
          d.beat = last_q ? 2'h0 : q.beat + 2'h1;
          if (q.remain == 8'h01) begin
            d.hold = 1'b0;
            d.cmd_oe_n = 1'b1;
            d.blast_n = 1'b1;
            d.gap = 2'h0;
            d.st = lbb_pkg::ST_GAP;
          end else if (last_q || rtn) begin
            // ready-return keeps the beat count; waits
            d.blast_n = 1'b1;
            d.st = lbb_pkg::ST_WAIT;
          end else begin
            d.blast_n = !last_beat(q.lin, d.beat, d.remain);
          end
        end
      end
      lbb_pkg::ST_BOFF: begin
        if (!boff) begin
          d.st = lbb_pkg::ST_WAIT;
          d.cmd_oe_n = 1'b0;
        end
      end
      lbb_pkg::ST_GAP: begin
        // request stays low for the gap
        if (q.gap == 2'(lbb_pkg::HOLD_GAP_CYC - 1)) begin
          d.st = lbb_pkg::ST_IDLE;
        end else begin
          d.gap = q.gap + 2'h1;
        end
      end
      default: d.st = lbb_pkg::ST_IDLE;
    endcase
    // back-off wins over a same-edge ready
    if (boff && ((q.st == lbb_pkg::ST_WAIT) || (q.st == lbb_pkg::ST_T1) ||
        (q.st == lbb_pkg::ST_T2))) begin
      d.st = lbb_pkg::ST_BOFF;
      d.addr = q.addr;
      d.remain = q.remain;
      d.push_v = 1'b0;
      // a last ready lost to back-off must not drop the bus request
      d.hold = q.hold;
      d.first = q.first;
      // partial burst dropped; address of the interrupted beat kept
      d.beat = 2'h0;
      d.ads_n = 1'b1;
      d.blast_n = 1'b1;
      d.cmd_oe_n = 1'b1;
    end
    d.rdy = d.st == lbb_pkg::ST_IDLE;
    owned = (d.st == lbb_pkg::ST_WAIT) || (d.st == lbb_pkg::ST_T1) ||
      (d.st == lbb_pkg::ST_T2);
    // float takes effect the cycle after hold is seen
    d.aoe_n = owned ? (ahold ? fmask : 30'h00000000) : 30'h3FFFFFFF;
  end

  always_ff @(posedge mclk or negedge rst_sn) begin
    if (!rst_sn) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // room is checked before every strobe, so push_ready never drops here
  assign fi.push_valid = q.push_v;
  assign fi.push_data = q.push_d;

  lbb_fifo #(.W(lbb_pkg::DATA_W), .D(lbb_pkg::FIFO_DEPTH)) u_fifo (
    .clk(mclk),
    .rst_sn(rst_sn),
    .f(fi),
    .out_valid(out_valid),
    .out_data(out_data),
    .out_ready(out_ready)
  );

  assign req_ready = q.rdy;
  assign cfg_rdata = q.cfg;
  assign hold_req = q.hold;
  assign ads_n = q.ads_n;
  assign blast_n = q.blast_n;
  assign cmd_oe_n = q.cmd_oe_n;
  assign addr_out = q.addr;
  assign addr_oe_n = q.aoe_n;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_sn);

  sequence s_boff_in_t2;
    q.st == lbb_pkg::ST_T2 && boff;
  endsequence
  sequence s_held_t2;
    (q.st == lbb_pkg::ST_T2 && ahold) ##1 (q.st == lbb_pkg::ST_T2);
  endsequence

  restart_addr_a: assert property (
    s_boff_in_t2 and (!q.first) |=>
      q.st == lbb_pkg::ST_BOFF && q.addr == $past(q.addr))
    else $error("restart address lost on back-off");
  aligned_burst_a: assert property (
    (q.st == lbb_pkg::ST_T1 && q.lin && q.beat == 2'h0) |->
      q.addr[1:0] == 2'h0)
    else $error("linear burst from unaligned address");
  boff_prio_a: assert property (
    s_boff_in_t2 and xfer |=>
      !q.push_v && q.remain == $past(q.remain))
    else $error("transfer counted under back-off");
  no_resume_a: assert property (
    s_boff_in_t2 |=> q.beat == 2'h0)
    else $error("partial burst kept across back-off");
  rtn_continue_a: assert property (
    (q.st == lbb_pkg::ST_T2 && q.lin && rtn && !brdy && !boff &&
      !last_q && q.remain > 8'h01) |=>
      q.st == lbb_pkg::ST_WAIT && q.lin && q.beat == $past(q.beat) + 2'h1)
    else $error("burst abandoned on ready-return");
  float_next_a: assert property (
    s_held_t2 |-> q.aoe_n == fmask)
    else $error("address not floated after hold");
  no_ads_hold_a: assert property (
    !q.ads_n |-> !$past(ahold))
    else $error("strobe issued under address hold");
  t1_suspend_a: assert property (
    (q.st == lbb_pkg::ST_T1 && ahold && !boff) |=>
      q.st == lbb_pkg::ST_WAIT && q.ads_n && q.addr == $past(q.addr))
    else $error("first state not suspended");
  wait_drive_a: assert property (
    q.st == lbb_pkg::ST_WAIT |-> q.ads_n && !q.cmd_oe_n)
    else $error("wait state drives wrong signals");
  same_addr_a: assert property (
    (q.st == lbb_pkg::ST_T2 && ahold && !xfer && !boff) |=>
      q.st == lbb_pkg::ST_T2 && q.ads_n && $stable(q.addr))
    else $error("address changed without ready");
  hold_gap_a: assert property (
    $fell(q.hold) |-> (!q.hold) [*2])
    else $error("hold request reasserted too soon");
endmodule

// file: hw/lbb_pkg.sv
package lbb_pkg;
  // bus widths: address words A31..A2 and data
  localparam int ADDR_W = 30;
  localparam int DATA_W = 32;
  localparam int LEN_W = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int ROOM_W = 4;
  // linear burst: four double words, 16-byte aligned start
  localparam int BURST_LEN = 4;
  localparam logic [ROOM_W-1:0] ROOM_MIN = 4'h5;
  // bus_config_reg_eighteen, cache_line_length_field at 15..11
  localparam int CFG_W = 16;
  localparam int CLL_LSB = 11;
  localparam int CLL_MSB = 15;
  localparam logic [15:0] CFG_RESET = 16'h2000;
  localparam logic [4:0] CLL_A2 = 5'h01;
  localparam logic [4:0] CLL_A3 = 5'h02;
  localparam logic [4:0] CLL_A4 = 5'h04;
  localparam logic [4:0] CLL_A5 = 5'h08;
  localparam logic [4:0] CLL_A6 = 5'h10;
  localparam logic [29:0] MASK_A2 = 30'h3FFFFFFF;
  localparam logic [29:0] MASK_A3 = 30'h3FFFFFFE;
  localparam logic [29:0] MASK_A4 = 30'h3FFFFFFC;
  localparam logic [29:0] MASK_A5 = 30'h3FFFFFF8;
  localparam logic [29:0] MASK_A6 = 30'h3FFFFFF0;
  // hold request stays low this many bus clocks; clock is the bus clock
  localparam int CLK_NS = 25;
  localparam int HOLD_GAP_BCLK = 2;
  localparam int HOLD_GAP_CYC = HOLD_GAP_BCLK * CLK_NS / CLK_NS;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_HREQ = 3'h1,
    ST_WAIT = 3'h2,
    ST_T1 = 3'h3,
    ST_T2 = 3'h4,
    ST_BOFF = 3'h5,
    ST_GAP = 3'h6
  } lbb_state_t;
endpackage

// file: tb/lbb_mem_model.sv
`timescale 1ns/10ps
module lbb_mem_model (
  // clock
  input wire logic mclk,
  // from the master; ahold and boff_n come from the test
  input wire logic hold_req,
  input wire logic ads_n,
  input wire logic blast_n,
  input wire logic ahold,
  input wire logic boff_n,
  input wire logic [29:0] addr_out,
  // scenario controls
  input wire logic stall,
  input wire logic [2:0] rr_at,
  // to the master
  output logic hold_ack,
  output logic brdy_n,
  output logic ready_return_input_n,
  output logic [31:0] bus_data
);
  logic cyc = 1'b0;
  logic [29:0] base = 30'h0;
  logic [2:0] beat = 3'h0;
  initial begin
    hold_ack = 1'b0;
    brdy_n = 1'b1;
    ready_return_input_n = 1'b1;
    bus_data = 32'h0;
  end
  //////////////////////////////////////////////////////////////////////
  // a cancelled first state opens no cycle
  always @(posedge mclk) begin
    if (!boff_n) begin
      cyc <= 1'b0;
    end else if (!ads_n && !ahold) begin
      cyc <= 1'b1;
      base <= addr_out;
      beat <= 3'h0;
    end else if (cyc && !(brdy_n && ready_return_input_n)) begin
      beat <= beat + 3'h1;
      if (!blast_n || !ready_return_input_n) begin
        cyc <= 1'b0;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////
  // driven off the sampling edge
  // ready lines pulled up when idle; data bus toggles once released
  always @(negedge mclk) begin
    hold_ack <= hold_req;
    if (cyc && !stall) begin
      brdy_n <= (beat + 3'h1 == rr_at);
      ready_return_input_n <= (beat + 3'h1 != rr_at);
      bus_data <= {2'h0, base + 30'(beat)};
    end else begin
      brdy_n <= 1'b1;
      ready_return_input_n <= 1'b1;
      bus_data <= ~bus_data;
    end
  end
endmodule

// file: tb/tb.sv
`timescale 1ns/10ps
module tb;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  logic [29:0] req_addr = 30'h0;
  logic [7:0] req_len = 8'h0;
  logic cfg_wr = 1'b0;
  logic [15:0] cfg_wdata = 16'h0;
  logic boff_n = 1'b1;
  logic ahold = 1'b0;
  logic out_ready = 1'b1;
  logic stall = 1'b0;
  logic [2:0] rr_at = 3'h0;
  logic req_ready, hold_req, hold_ack, ads_n, blast_n, cmd_oe_n;
  logic brdy_n, ready_return_input_n, out_valid;
  logic [15:0] cfg_rdata;
  logic [29:0] addr_out, addr_oe_n;
  logic [31:0] bus_data, out_data;
  int miscompares = 0;
  int num_checks = 0;
  int nads = 0;
  int nlast = 0;
  int gap = 0;
  int bad_gap = 0;
  logic [29:0] ads_q[$];
  logic [31:0] got[$];
  always #12.5 mclk = ~mclk;
  lbb_master DUT (.mclk, .rst_n, .req_valid, .req_addr, .req_len,
    .req_ready, .cfg_wr, .cfg_wdata, .cfg_rdata, .hold_req, .hold_ack,
    .boff_n, .ahold, .ads_n, .blast_n, .cmd_oe_n, .addr_out, .addr_oe_n,
    .brdy_n, .ready_return_input_n, .bus_data, .out_valid, .out_data,
    .out_ready);
  lbb_mem_model mem (.mclk, .hold_req, .ads_n, .blast_n, .ahold, .boff_n,
    .addr_out, .stall, .rr_at, .hold_ack, .brdy_n, .ready_return_input_n,
    .bus_data);
  //////////////////////////////////////////////////////////////////////
  always @(posedge mclk) begin
    if (!ads_n) begin
      nads <= nads + 1;
      ads_q.push_back(addr_out);
    end
    if (!blast_n && !brdy_n) nlast <= nlast + 1;
    if (out_valid && out_ready) got.push_back(out_data);
    gap <= hold_req ? 0 : gap + 1;
    if (hold_req && gap > 0 && gap < 2) bad_gap <= bad_gap + 1;
  end
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] seen);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic wait_got(input int n);
    for (int i = 0; i < 300 && got.size() < n; i++) @(posedge mclk);
  endtask
  // returns on the falling edge after the n-th strobe was sampled
  task automatic wait_ads(input int n);
    @(negedge mclk);
    for (int i = 0; i < 200 && nads < n; i++) @(negedge mclk);
  endtask
  task automatic run(input logic [29:0] a, input int n);
    nads = 0;
    nlast = 0;
    ads_q.delete();
    got.delete();
    @(negedge mclk);
    for (int i = 0; i < 50 && !req_ready; i++) @(negedge mclk);
    req_valid = 1'b1;
    req_addr = a;
    req_len = 8'(n);
    @(negedge mclk);
    req_valid = 1'b0;
    wait_got(n);
    for (int i = 0; i < n; i++) chk("data", {2'h0, a + 30'(i)}, got[i]);
  endtask
  //////////////////////////////////////////////////////////////////////
  task automatic t_fill();
    out_ready = 1'b0;
    fork
      run(30'h100, 12);
      begin
        repeat (40) @(negedge mclk);
        // two bursts fill the buffer; the third strobe waits for room
        chk("stalled strobes", 32'h2, nads);
        out_ready = 1'b1;
      end
    join
    chk("strobes", 32'h3, nads);
    $display("fill test done");
  endtask
  task automatic t_boff(input logic [29:0] a, input int late);
    fork
      run(a, 4);
      begin
        wait_ads(1);
        repeat (late) @(negedge mclk);
        boff_n = 1'b0;
        repeat (3) @(negedge mclk);
        boff_n = 1'b1;
      end
    join
    chk("strobes", late ? 32'h4 : 32'h2, nads);
    chk("next addr", {2'h0, a + 30'(late)}, {2'h0, ads_q[1]});
    chk("burst ends", late ? 32'h3 : 32'h1, nlast);
    $display("back-off test done");
  endtask
  task automatic t_rr();
    rr_at = 3'h2;
    run(30'h400, 4);
    rr_at = 3'h0;
    chk("strobes", 32'h2, nads);
    chk("next addr", 32'h402, {2'h0, ads_q[1]});
    $display("ready-return test done");
  endtask
  task automatic t_ahold_mid();
    logic [4:0] code[7] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h08, 5'h10,
      5'h03};
    logic [29:0] mask[7] = '{30'h0, 30'h3FFFFFFF, 30'h3FFFFFFE,
      30'h3FFFFFFC, 30'h3FFFFFF8, 30'h3FFFFFF0, 30'h0};
    for (int k = 0; k < 7; k++) begin
      @(negedge mclk);
      cfg_wr = 1'b1;
      cfg_wdata = {code[k], 11'h0};
      @(negedge mclk);
      cfg_wr = 1'b0;
      chk("cfg", {16'h0, code[k], 11'h0}, {16'h0, cfg_rdata});
      stall = 1'b1;
      fork
        run(30'h500, 8);
        begin
          wait_ads(1);
          ahold = 1'b1;
          @(negedge mclk);
          chk("float", {2'h0, mask[k]}, {2'h0, addr_oe_n});
          ahold = 1'b0;
          @(negedge mclk);
          chk("same addr", 32'h500, {2'h0, addr_out});
          chk("redriven", 32'h0, {2'h0, addr_oe_n});
          chk("no restrobe", 32'h1, nads);
          ahold = 1'b1;
          stall = 1'b0;
          wait_got(4);
          @(negedge mclk);
          chk("held strobes", 32'h1, nads);
          ahold = 1'b0;
        end
      join
      chk("strobes", 32'h2, nads);
    end
    $display("address hold test done");
  endtask
  task automatic t_ahold_t1();
    fork
      run(30'h600, 4);
      begin
        for (int i = 0; i < 200 && ads_n; i++) @(negedge mclk);
        ahold = 1'b1;
        repeat (3) @(negedge mclk);
        chk("strobe off", 32'h1, {31'h0, ads_n});
        chk("commands on", 32'h0, {31'h0, cmd_oe_n});
        ahold = 1'b0;
      end
    join
    chk("strobes", 32'h2, nads);
    chk("intended addr", 32'h600, {2'h0, ads_q[1]});
    $display("first-state hold test done");
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    chk("cfg reset", 32'h2000, {16'h0, cfg_rdata});
    chk("reset float", 32'h3FFFFFFF, {2'h0, addr_oe_n});
    $display("reset test done");
    t_fill();
    t_boff(30'h200, 0);
    t_boff(30'h300, 1);
    t_rr();
    t_ahold_mid();
    t_ahold_t1();
    chk("hold gap", 32'h0, bad_gap);
    final_report();
  end
  // tests need under 1500 clocks; 6000 leaves margin
  initial begin
    #150000;
    miscompares++;
    final_report();
  end
endmodule
